// file: mcps_pkg.sv
// Package for the motor controller parameter store: register map,
// reset values, field positions and the shared carrier types.
// Assumes byte addressing on a 32-bit classic Wishbone bus.
`default_nettype none

package mcps_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_FLUX_P = 8'h00;
  localparam logic [7:0] A_FLUX_I = 8'h04;
  localparam logic [7:0] A_TORQ_P = 8'h08;
  localparam logic [7:0] A_TORQ_I = 8'h0C;
  localparam logic [7:0] A_OPEN_P = 8'h10;
  localparam logic [7:0] A_OPEN_I = 8'h14;
  localparam logic [7:0] A_VEL_FF = 8'h18;
  localparam logic [7:0] A_ACC_FF = 8'h1C;
  localparam logic [7:0] A_DF_CNT = 8'h20;
  localparam logic [7:0] A_DF_RSVD = 8'h24;
  localparam logic [7:0] A_FIELD = 8'h28;
  localparam logic [7:0] A_KEEP = 8'h2C;
  localparam logic [7:0] A_CTRL = 8'h30;
  localparam logic [7:0] A_STAT = 8'h34;
  localparam int N_GAINS = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_FLUX_P = 32'h0088_1EE0;
  localparam logic [31:0] RST_FLUX_I = 32'h0007_C740;
  localparam logic [31:0] RST_TORQ_P = 32'h0088_1EE0;
  localparam logic [31:0] RST_TORQ_I = 32'h0007_C740;
  localparam logic [31:0] RST_OPEN_P = 32'h004D_C880;
  localparam logic [31:0] RST_OPEN_I = 32'h001D_2B30;
  localparam logic [31:0] RST_VEL_FF = 32'h0000_03E8;
  localparam logic [31:0] RST_ACC_FF = 32'h0000_0000;
  localparam logic [7:0] DF_COUNT = 8'h03;
  localparam logic [7:0] RST_FLAG = 8'h00;

  // Field inversion override codes, signed 8-bit
  localparam logic [7:0] FIELD_DEFAULT = 8'h00;
  localparam logic [7:0] FIELD_POS = 8'h01;
  localparam logic [7:0] FIELD_NEG = 8'hFF;
  localparam logic [7:0] KEEP_ON = 8'h01;

  // Control and status bit positions
  localparam int CTRL_RESTART = 0;
  localparam int CTRL_SETUP = 1;
  localparam int CTRL_DONE_CLR = 2;
  localparam int ST_INVERT = 0;
  localparam int ST_FORCED = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_DONE = 3;
  localparam int ST_NEEDED = 4;
  localparam int ST_BLDC = 5;

  // Gains and feed-forward factors as one carrier
  typedef struct packed {
    logic [31:0] acc_ff;
    logic [31:0] vel_ff;
    logic [31:0] open_i;
    logic [31:0] open_p;
    logic [31:0] torq_i;
    logic [31:0] torq_p;
    logic [31:0] flux_i;
    logic [31:0] flux_p;
  } mcps_gains_t;

  // Rotating field as applied to the drive
  typedef struct packed {
    logic invert;
    logic forced;
  } mcps_field_t;

endpackage

`default_nettype wire

// file: mcps_top.sv
// Motor controller parameter store: current loop gains, feed-forward
// factors, motor drive flags, restart and auto setup sequencing.
// Assumes a classic Wishbone master and a motor type detect input.
//
// How it works
// - Flux proportional gain, 32-bit read/write, resets to 0x00881EE0.
// - Flux integral gain, 32-bit read/write, resets to 0x0007C740.
// - Torque closed-loop gains, read/write, reset 0x00881EE0 and 0x0007C740.
// - Torque open-loop gains, read/write, reset 0x004DC880 and 0x001D2B30.
// - Velocity feed-forward in per mille; default 1000 means factor one.
// - Acceleration feed-forward defaults zero (off); nonzero acts both ways.
// - Drive flags group reports three entries, read only.
// - Field override zero selects the built-in rotating field direction.
// - Field override one forces a non-inverted, positive field.
// - Field override minus one forces an inverted, negative field.
// - Field override applies only at restart; auto setup needed if the applied field changes.
// - Keep flag zero: auto setup detects motor and loads preset gains.
// - Keep flag one: auto setup keeps the stored gains untouched.
`timescale 1ns/100ps
`default_nettype none

module mcps_top #(
  parameter int AW = 8,
  parameter bit DEFAULT_INVERT = 1'b0,
  parameter logic [31:0] BLDC_PROP = 32'h0000_1000,
  parameter logic [31:0] BLDC_INT = 32'h0000_0100
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [AW-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic MOTOR_IS_BLDC,
  output mcps_pkg::mcps_gains_t GAINS,
  output mcps_pkg::mcps_field_t FIELD,
  output logic ACCEL_FF_ON,
  output logic SETUP_BUSY
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (AW < 8)
  begin : g_bad_aw
    $error("AW must be at least 8");
  end

  typedef enum logic [1:0] {AS_IDLE, AS_DETECT, AS_LOAD} mcps_as_t;
  // Reset value of each gain word
  function automatic logic [31:0] gain_rst(input int idx);
    case (idx)
      0: return mcps_pkg::RST_FLUX_P;
      1: return mcps_pkg::RST_FLUX_I;
      2: return mcps_pkg::RST_TORQ_P;
      3: return mcps_pkg::RST_TORQ_I;
      4: return mcps_pkg::RST_OPEN_P;
      5: return mcps_pkg::RST_OPEN_I;
      6: return mcps_pkg::RST_VEL_FF;
      default: return mcps_pkg::RST_ACC_FF;
    endcase
  endfunction

  // Preset gain set for the detected motor type
  function automatic logic [31:0] gain_preset(input int idx,
                                              input logic bldc);
    if (bldc && idx < 6)
      return idx[0] ? BLDC_INT : BLDC_PROP;
    return gain_rst(idx);
  endfunction

  // Field override to applied direction; unknown codes act as zero
  function automatic mcps_pkg::mcps_field_t field_of(input logic [7:0] c);
    mcps_pkg::mcps_field_t f;
    f.forced = c == mcps_pkg::FIELD_POS || c == mcps_pkg::FIELD_NEG;
    f.invert = f.forced ? c == mcps_pkg::FIELD_NEG : DEFAULT_INVERT;
    return f;
  endfunction

  // Byte-lane merge for 32-bit entries
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        v[8*b +: 8] = nw[8*b +: 8];
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic req;
  logic wr;
  logic [7:0] adr;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_d;
  logic [31:0] gain_q [mcps_pkg::N_GAINS];
  logic [7:0] rsvd_q;
  logic [7:0] field_q;
  logic [7:0] keep_q;
  mcps_pkg::mcps_field_t applied_q;
  logic restart_q;
  logic done_q;
  logic needed_q;
  logic bldc_q;
  logic accff_q;
  mcps_as_t as_q;
  logic busy_q;
  logic ctrl_wr;
  logic gain_wr;

  // Request taken once; a write lands on the edge that sees ack high
  assign req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && ack_q;
  assign adr = {WB_ADR_I[7:2], 2'b00};
  assign ctrl_wr = wr && adr == mcps_pkg::A_CTRL && WB_SEL_I[0];
  assign gain_wr = wr && adr < mcps_pkg::A_DF_CNT;

  // Single-wait-state answer, every address acknowledged
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // ---------------------------------------------------------------
  // Gain and feed-forward words
  // ---------------------------------------------------------------
  // Auto setup load wins over a bus write in the same cycle
  always_ff @(posedge SYS_CLK)
  begin
    for (int i = 0; i < mcps_pkg::N_GAINS; i++)
    begin
      if (!RST_N)
        gain_q[i] <= gain_rst(i);
      else if (as_q == AS_LOAD && keep_q != mcps_pkg::KEEP_ON)
        gain_q[i] <= gain_preset(i, bldc_q);
      else if (gain_wr && adr[4:2] == 3'(i))
        gain_q[i] <= merge(gain_q[i], WB_DAT_I, WB_SEL_I);
    end
  end

  // Feed-forward has no sign, so it acts while slowing down too
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      accff_q <= 1'b0;
    else
      accff_q <= gain_q[7] != 32'h0000_0000;
  end

  // ---------------------------------------------------------------
  // Motor drive flags
  // ---------------------------------------------------------------
  // Reserved entry only echoes; nothing downstream reads it
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rsvd_q <= mcps_pkg::RST_FLAG;
      field_q <= mcps_pkg::RST_FLAG;
      keep_q <= mcps_pkg::RST_FLAG;
    end
    else if (wr && WB_SEL_I[0])
    begin
      if (adr == mcps_pkg::A_DF_RSVD)
        rsvd_q <= WB_DAT_I[7:0];
      if (adr == mcps_pkg::A_FIELD)
        field_q <= WB_DAT_I[7:0];
      if (adr == mcps_pkg::A_KEEP)
        keep_q <= WB_DAT_I[7:0];
    end
  end

  // Restart request, one cycle after the control write
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      restart_q <= 1'b0;
    else
      restart_q <= ctrl_wr && WB_DAT_I[mcps_pkg::CTRL_RESTART];
  end

  // Direction latched only at restart so a live motor never flips
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      applied_q.invert <= DEFAULT_INVERT;
      applied_q.forced <= 1'b0;
    end
    else if (restart_q)
      applied_q <= field_of(field_q);
  end

  // ---------------------------------------------------------------
  // Auto setup
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      as_q <= AS_IDLE;
    else
    begin
      unique case (as_q)
        AS_IDLE:
          if (ctrl_wr && WB_DAT_I[mcps_pkg::CTRL_SETUP])
            as_q <= AS_DETECT;
        AS_DETECT: as_q <= AS_LOAD;
        AS_LOAD: as_q <= AS_IDLE;
      endcase
    end
  end

  // Busy from its own flop, raised as the state machine leaves idle
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      busy_q <= 1'b0;
    else
      busy_q <= as_q == AS_DETECT ||
        (as_q == AS_IDLE && ctrl_wr && WB_DAT_I[mcps_pkg::CTRL_SETUP]);
  end

  // Motor type sampled once per setup run
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      bldc_q <= 1'b0;
    else if (as_q == AS_DETECT)
      bldc_q <= MOTOR_IS_BLDC;
  end

  // Sticky done; completion wins over a clear in the same cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      done_q <= 1'b0;
    else if (as_q == AS_LOAD)
      done_q <= 1'b1;
    else if (ctrl_wr && WB_DAT_I[mcps_pkg::CTRL_DONE_CLR])
      done_q <= 1'b0;
  end

  // A restart that changes direction asks for a fresh auto setup
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      needed_q <= 1'b0;
    else if (restart_q && field_of(field_q) != applied_q)
      needed_q <= 1'b1;
    else if (as_q == AS_LOAD)
      needed_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (adr < mcps_pkg::A_DF_CNT)
      rd_d = gain_q[adr[4:2]];
    else if (adr == mcps_pkg::A_DF_CNT)
      rd_d[7:0] = mcps_pkg::DF_COUNT;
    else if (adr == mcps_pkg::A_DF_RSVD)
      rd_d[7:0] = rsvd_q;
    else if (adr == mcps_pkg::A_FIELD)
      rd_d[7:0] = field_q;
    else if (adr == mcps_pkg::A_KEEP)
      rd_d[7:0] = keep_q;
    else if (adr == mcps_pkg::A_STAT)
    begin
      rd_d[mcps_pkg::ST_INVERT] = applied_q.invert;
      rd_d[mcps_pkg::ST_FORCED] = applied_q.forced;
      rd_d[mcps_pkg::ST_BUSY] = as_q != AS_IDLE;
      rd_d[mcps_pkg::ST_DONE] = done_q;
      rd_d[mcps_pkg::ST_NEEDED] = needed_q;
      rd_d[mcps_pkg::ST_BLDC] = bldc_q;
    end
  end

  // Read data captured with the ack, so it is stable while ack is up
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      dat_q <= 32'h0000_0000;
    else if (req)
      dat_q <= rd_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign GAINS = {gain_q[7], gain_q[6], gain_q[5], gain_q[4],
                  gain_q[3], gain_q[2], gain_q[1], gain_q[0]};
  assign FIELD = applied_q;
  assign ACCEL_FF_ON = accff_q;
  assign SETUP_BUSY = busy_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_setup_keep;
    as_q == AS_DETECT && keep_q == mcps_pkg::KEEP_ON ##1 as_q == AS_LOAD;
  endsequence
  sequence s_setup_bldc;
    as_q == AS_DETECT && keep_q == mcps_pkg::RST_FLAG && MOTOR_IS_BLDC
      ##1 as_q == AS_LOAD;
  endsequence
  sequence s_rsvd_write;
    wr && adr == mcps_pkg::A_DF_RSVD && WB_SEL_I[0];
  endsequence
  a_gain_reset: assert property ($past(!RST_N) |->
      gain_q[0] == 32'h0088_1EE0 && gain_q[1] == 32'h0007_C740 &&
      gain_q[2] == 32'h0088_1EE0 && gain_q[3] == 32'h0007_C740 &&
      gain_q[4] == 32'h004D_C880 && gain_q[5] == 32'h001D_2B30)
    else $error("gain reset value wrong");
  a_ff_reset: assert property ($past(!RST_N) |->
      gain_q[6] == 32'd1000 && gain_q[7] == 32'h0000_0000)
    else $error("feed-forward reset value wrong");
  a_accff_flag: assert property (##1 accff_q ==
      ($past(gain_q[7]) != 32'h0000_0000))
    else $error("accel feed-forward enable wrong");
  a_count_read: assert property (req && !WB_WE_I &&
      adr == mcps_pkg::A_DF_CNT |=> WB_ACK_O && WB_DAT_O == 32'h0000_0003)
    else $error("entry count not three");
  a_field_hold: assert property (!restart_q |=> $stable(applied_q))
    else $error("field changed without restart");
  a_field_pos: assert property (restart_q && field_q == 8'h01 |=>
      FIELD.forced && !FIELD.invert)
    else $error("positive field not forced");
  a_field_neg: assert property (restart_q && field_q == 8'hFF |=>
      FIELD.forced && FIELD.invert)
    else $error("negative field not forced");
  a_field_dflt: assert property (restart_q && field_q == 8'h00 |=>
      !FIELD.forced && FIELD.invert == DEFAULT_INVERT)
    else $error("default field not used");
  a_keep_gains: assert property (s_setup_keep |->
      ##1 (GAINS == $past(GAINS) || $past(gain_wr)))
    else $error("keep flag gains modified");
  a_bldc_load: assert property (s_setup_bldc |=>
      gain_q[0] == BLDC_PROP && gain_q[1] == BLDC_INT && done_q)
    else $error("preset gains not loaded");
  a_rsvd_echo: assert property (s_rsvd_write |=>
      (rsvd_q == $past(WB_DAT_I[7:0])) and ($stable(FIELD) [*2]))
    else $error("reserved entry not stored");
  a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
endmodule // mcps_top

`default_nettype wire

// file: mcps_tb.sv
// Self-checking bench for the motor controller parameter store.
// Assumes the store answers each Wishbone access one cycle after it
// is taken, and drives every input port of the store from this module.
`timescale 1ns/100ps
`default_nettype none

module testbench;

  // ---------------------------------------------------------------
  // Signals and tables
  // ---------------------------------------------------------------
  localparam logic [31:0] bldc_p = 32'h0000_1234;
  localparam logic [31:0] bldc_i = 32'h0000_0056;
  logic sys_clk;
  logic rst_n;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic is_bldc;
  mcps_pkg::mcps_gains_t gains;
  mcps_pkg::mcps_field_t field;
  mcps_pkg::mcps_field_t pre;
  logic acc_on;
  logic busy;
  logic [31:0] q;
  logic [31:0] pat;
  int err_total;
  int checked;
  logic [7:0] addr_t [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
    8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  logic [31:0] rst_t [12] = '{mcps_pkg::RST_FLUX_P, mcps_pkg::RST_FLUX_I,
    mcps_pkg::RST_TORQ_P, mcps_pkg::RST_TORQ_I, mcps_pkg::RST_OPEN_P,
    mcps_pkg::RST_OPEN_I, mcps_pkg::RST_VEL_FF, mcps_pkg::RST_ACC_FF,
    32'h0000_0003, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic [7:0] code_t [3] = '{8'h01, 8'hFF, 8'h00};
  logic [1:0] fld_t [3] = '{2'b01, 2'b11, 2'b10};

  // Built-in direction set to inverted so that code zero is visible
  mcps_top #(
    .AW(8),
    .DEFAULT_INVERT(1'b1),
    .BLDC_PROP(bldc_p),
    .BLDC_INT(bldc_i)
  ) i_mcps_top (
    .SYS_CLK(sys_clk),
    .RST_N(rst_n),
    .WB_CYC_I(cyc),
    .WB_STB_I(stb),
    .WB_WE_I(we),
    .WB_ADR_I(adr),
    .WB_SEL_I(sel),
    .WB_DAT_I(wdat),
    .WB_DAT_O(rdat),
    .WB_ACK_O(ack),
    .MOTOR_IS_BLDC(is_bldc),
    .GAINS(gains),
    .FIELD(field),
    .ACCEL_FF_ON(acc_on),
    .SETUP_BUSY(busy)
  );

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------
  // Bus and checking tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb_acc(input logic w, input logic [7:0] a,
    input logic [3:0] s, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50)
      chk("ack wait", 32'h0000_0001, 32'h0000_0000);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb_acc(1'b1, a, 4'hF, d, r);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb_acc(1'b0, a, 4'hF, 32'h0000_0000, r);
    chk($sformatf("entry %h", a), e, r);
  endtask

  // Starts auto setup, waits for done, then clears done
  task automatic run_setup();
    logic [31:0] r;
    int n;
    wr(mcps_pkg::A_CTRL, 32'h0000_0002);
    // Busy port looked at mid-cycle, once the start edge has settled
    @(negedge sys_clk);
    chk("setup busy", 32'h0000_0001, {31'h0, busy});
    r = 32'h0000_0000;
    for (n = 0; n < 10 && r[mcps_pkg::ST_DONE] !== 1'b1; n++)
      wb_acc(1'b0, mcps_pkg::A_STAT, 4'hF, 32'h0000_0000, r);
    chk("setup done", 32'h0000_0001, {31'h0, r[mcps_pkg::ST_DONE]});
    chk("setup idle", 32'h0000_0000, {31'h0, busy});
    wr(mcps_pkg::A_CTRL, 32'h0000_0004);
    wb_acc(1'b0, mcps_pkg::A_STAT, 4'hF, 32'h0000_0000, r);
    chk("done clr", 32'h0000_0000, {31'h0, r[mcps_pkg::ST_DONE]});
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  // Watchdog well beyond the few hundred cycles the accesses below take
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  initial
  begin
    err_total = 0;
    checked = 0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    is_bldc = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Power-up values on the bus and at the ports
    for (int i = 0; i < 12; i++)
      chk_rd(addr_t[i], rst_t[i]);
    chk("flux p port", mcps_pkg::RST_FLUX_P, gains.flux_p);
    chk("open i port", mcps_pkg::RST_OPEN_I, gains.open_i);
    chk("accel on", 32'h0000_0000, {31'h0, acc_on});
    chk("field reset", 32'h0000_0002, {30'h0, field});
    // Every gain word stored, returned and driven out
    for (int i = 0; i < 8; i++)
    begin
      pat = 32'h1357_9BDF ^ {24'h0, addr_t[i]};
      wr(addr_t[i], pat);
      chk_rd(addr_t[i], pat);
      chk("gain port", pat, gains[i*32 +: 32]);
    end
    chk("accel on", 32'h0000_0001, {31'h0, acc_on});
    // Byte lane write touches only its lane
    pat = 32'h1357_9BDF ^ 32'h0000_0018;
    wb_acc(1'b1, mcps_pkg::A_VEL_FF, 4'b0010, 32'hAABB_CCDD, q);
    chk_rd(mcps_pkg::A_VEL_FF, {pat[31:16], 8'hCC, pat[7:0]});
    wr(mcps_pkg::A_ACC_FF, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    chk("accel off", 32'h0000_0000, {31'h0, acc_on});
    wr(mcps_pkg::A_ACC_FF, 32'h0000_0001);
    // Count is read only; reserved stores without effect
    wr(mcps_pkg::A_DF_CNT, 32'hFFFF_FFFF);
    chk_rd(mcps_pkg::A_DF_CNT, 32'h0000_0003);
    wr(mcps_pkg::A_DF_RSVD, 32'h0000_005A);
    chk_rd(mcps_pkg::A_DF_RSVD, 32'h0000_005A);
    wr(mcps_pkg::A_CTRL, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chk("field rsvd", 32'h0000_0002, {30'h0, field});
    wr(8'h40, 32'hFFFF_FFFF);
    chk_rd(8'h40, 32'h0000_0000);
    // Override codes act only at restart
    for (int i = 0; i < 3; i++)
    begin
      pre = field;
      wr(mcps_pkg::A_FIELD, {24'h0, code_t[i]});
      repeat (3) @(posedge sys_clk);
      chk("field early", {30'h0, pre}, {30'h0, field});
      wr(mcps_pkg::A_CTRL, 32'h0000_0001);
      repeat (3) @(posedge sys_clk);
      chk("field", {30'h0, fld_t[i]}, {30'h0, field});
      wb_acc(1'b0, mcps_pkg::A_STAT, 4'hF, 32'h0000_0000, q);
      chk("needed", 32'h0000_0001, {31'h0, q[4]});
    end
    // Keep flag set: stored gains survive auto setup
    wr(mcps_pkg::A_KEEP, 32'h0000_0001);
    run_setup();
    chk_rd(mcps_pkg::A_FLUX_P, 32'h1357_9BDF);
    chk_rd(mcps_pkg::A_OPEN_I, 32'h1357_9BCB);
    wb_acc(1'b0, mcps_pkg::A_STAT, 4'hF, 32'h0000_0000, q);
    chk("needed clr", 32'h0000_0000, {31'h0, q[4]});
    // Keep flag clear: detected motor selects the preset
    wr(mcps_pkg::A_KEEP, 32'h0000_0000);
    run_setup();
    for (int i = 0; i < 6; i++)
      chk_rd(addr_t[i], i[0] ? bldc_i : bldc_p);
    chk_rd(mcps_pkg::A_VEL_FF, mcps_pkg::RST_VEL_FF);
    chk("flux p port", bldc_p, gains.flux_p);
    is_bldc <= 1'b0;
    run_setup();
    for (int i = 0; i < 8; i++)
      chk_rd(addr_t[i], rst_t[i]);
    give_verdict();
  end

endmodule // testbench

`default_nettype wire
